// [shared/icache_pkg.sv]
package icache_pkg;

    // array geometry
    localparam int ENTRIES = 64;
    localparam int INDEX_W = 6;
    localparam int ADDR_TAG_W = 24;
    localparam int TAG_W = 25;
    localparam int LINE_W = 32;
    localparam int WORD_W = 16;

    // fields of a prefetch address
    localparam int INDEX_LSB = 2;
    localparam int INDEX_MSB = 7;
    localparam int TAG_LSB = 8;
    localparam int TAG_MSB = 31;
    localparam int WORD_SEL_BIT = 1;
    localparam int SPACE_TAG_BIT = 2;

    // control register bit positions
    localparam int CTL_ENABLE_BIT = 0;
    localparam int CTL_FREEZE_BIT = 1;
    localparam int CTL_CLEAR_ENTRY_BIT = 2;
    localparam int CTL_CLEAR_ALL_BIT = 3;

    // control register selector on the move-to-control port
    localparam logic SEL_CONTROL = 1'h0;
    localparam logic SEL_ENTRY_ADDRESS = 1'h1;

    // reset values
    localparam logic ENABLE_RESET = 1'h0;
    localparam logic FREEZE_RESET = 1'h0;
    localparam logic [INDEX_W-1:0] ENTRY_INDEX_RESET = 6'h00;

    // prefetch sequencer
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXTERNAL = 2'b01
    } fetch_state_t;

endpackage

// [verilog/direct_mapped_instruction_cache.sv]
`timescale 1ns/1ps
module direct_mapped_instruction_cache (
    input wire logic clock,
    input wire logic resetn,
    // processor prefetch and operand read requests
    input wire logic fetch_req,
    input wire logic fetch_is_instruction,
    input wire logic [31:0] fetch_addr,
    input wire logic [2:0] fetch_space_code,
    output logic fetch_done,
    output logic [15:0] fetch_data,
    output logic fetch_from_cache,
    // move-to-control register port
    input wire logic ctl_valid,
    input wire logic ctl_write,
    input wire logic ctl_select,
    input wire logic ctl_supervisor,
    input wire logic [31:0] ctl_wdata,
    output logic ctl_ack,
    output logic ctl_privilege_error,
    output logic [31:0] ctl_rdata,
    // external bus fetch
    output logic ext_req,
    output logic [31:0] ext_addr,
    output logic [2:0] ext_space_code,
    input wire logic ext_ack,
    input wire logic [31:0] ext_data,
    // emulator cache disable, active low
    input wire logic cache_inhibit_pin_n
);

    localparam int N = icache_pkg::ENTRIES;
    localparam int IW = icache_pkg::INDEX_W;
    localparam int TW = icache_pkg::TAG_W;
    localparam int LW = icache_pkg::LINE_W;
    localparam int WW = icache_pkg::WORD_W;

    // cache array; tags and data need no reset, only valid bits do
    logic [TW-1:0] tag_mem [N];
    logic [LW-1:0] data_mem [N];
    logic [N-1:0] valid;

    // control state
    logic enable;
    logic freeze;
    logic [IW-1:0] entry_index;

    icache_pkg::fetch_state_t state;
    icache_pkg::fetch_state_t next_state;

    // captured request while the external fetch runs
    logic [IW-1:0] pend_index;
    logic [TW-1:0] pend_tag;
    logic pend_word;
    logic pend_fill;

    // request decode
    wire [IW-1:0] req_index =
        fetch_addr[icache_pkg::INDEX_MSB:icache_pkg::INDEX_LSB];
    // the upper address byte stays in the tag even when not driven out
    wire [TW-1:0] req_tag = {fetch_space_code[icache_pkg::SPACE_TAG_BIT],
        fetch_addr[icache_pkg::TAG_MSB:icache_pkg::TAG_LSB]};
    wire req_word = fetch_addr[icache_pkg::WORD_SEL_BIT];

    // inhibit gates use only; it never touches valid bits
    wire inhibited = !cache_inhibit_pin_n;
    wire cache_on = enable && !inhibited;
    wire cacheable = cache_on && fetch_is_instruction;
    wire idle = (state == icache_pkg::ST_IDLE);
    wire take_req = idle && fetch_req;

    wire [TW-1:0] sel_tag = tag_mem[req_index];
    wire [LW-1:0] sel_line = data_mem[req_index];
    wire tag_match = (sel_tag == req_tag);
    wire hit = cacheable && tag_match && valid[req_index];
    wire miss = take_req && !hit;
    wire [WW-1:0] hit_word =
        req_word ? sel_line[WW-1:0] : sel_line[LW-1:WW];
    wire [WW-1:0] ext_word =
        pend_word ? ext_data[WW-1:0] : ext_data[LW-1:WW];

    // a fill happens on the last cycle of an external fetch
    wire fill_now = (state == icache_pkg::ST_EXTERNAL) && ext_ack
        && pend_fill;

    // control port decode
    wire ctl_allowed = ctl_valid && ctl_supervisor;
    wire ctl_denied = ctl_valid && !ctl_supervisor;
    wire ctl_wr_control = ctl_allowed && ctl_write
        && (ctl_select == icache_pkg::SEL_CONTROL);
    wire ctl_wr_entry = ctl_allowed && ctl_write
        && (ctl_select == icache_pkg::SEL_ENTRY_ADDRESS);
    wire clear_all = ctl_wr_control
        && ctl_wdata[icache_pkg::CTL_CLEAR_ALL_BIT];
    // clear-entry ignores enable and freeze
    wire clear_entry = ctl_wr_control
        && ctl_wdata[icache_pkg::CTL_CLEAR_ENTRY_BIT];

    // read view: clear bits and bits 31..4 read as zero
    wire [31:0] control_view = {28'h0000000, 2'b00, freeze,
        enable};
    wire [31:0] entry_view = {24'h000000, entry_index,
        2'b00};
    wire [31:0] read_view = (ctl_select == icache_pkg::SEL_CONTROL) ?
        control_view : entry_view;

    // sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            icache_pkg::ST_IDLE: begin
                if (miss) begin
                    next_state = icache_pkg::ST_EXTERNAL;
                end
            end
            icache_pkg::ST_EXTERNAL: begin
                if (ext_ack) begin
                    next_state = icache_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            state <= icache_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // capture a missed request; fill is decided when the miss is taken
    always_ff @(posedge clock) begin
        if (!resetn) begin
            pend_index <= '0;
            pend_tag <= '0;
            pend_word <= 1'b0;
            pend_fill <= 1'b0;
        end else if (miss) begin
            pend_index <= req_index;
            pend_tag <= req_tag;
            pend_word <= req_word;
            pend_fill <= cacheable && !freeze;
        end
    end

    // external bus request; the low two address bits are forced to zero
    // so the whole entry comes back in one long-word read
    always_ff @(posedge clock) begin
        if (!resetn) begin
            ext_req <= 1'b0;
            ext_addr <= '0;
            ext_space_code <= '0;
        end else if (miss) begin
            ext_req <= 1'b1;
            ext_addr <= {fetch_addr[31:icache_pkg::INDEX_LSB], 2'b00};
            ext_space_code <= fetch_space_code;
        end else if (ext_ack) begin
            ext_req <= 1'b0;
        end
    end

    // answer to the processor
    always_ff @(posedge clock) begin
        if (!resetn) begin
            fetch_done <= 1'b0;
            fetch_data <= '0;
            fetch_from_cache <= 1'b0;
        end else if (take_req && hit) begin
            fetch_done <= 1'b1;
            fetch_data <= hit_word;
            fetch_from_cache <= 1'b1;
        end else if ((state == icache_pkg::ST_EXTERNAL) && ext_ack) begin
            fetch_done <= 1'b1;
            fetch_data <= ext_word;
            fetch_from_cache <= 1'b0;
        end else begin
            fetch_done <= 1'b0;
        end
    end

    // tag and data store; both words are written on every fill
    always_ff @(posedge clock) begin
        if (fill_now) begin
            tag_mem[pend_index] <= pend_tag;
            data_mem[pend_index] <= ext_data;
        end
    end

    // valid bits, one flop per entry; software clears beat a fill of
    // the same entry in the same cycle; a fill that ends later sets it again
    generate
        for (genvar i = 0; i < N; i++) begin : g_valid
            wire hit_entry = clear_entry
                && (entry_index == IW'(i));
            wire fill_entry = fill_now && (pend_index == IW'(i));
            always_ff @(posedge clock) begin
                if (!resetn) begin
                    valid[i] <= 1'b0;
                end else if (clear_all || hit_entry) begin
                    valid[i] <= 1'b0;
                end else if (fill_entry) begin
                    valid[i] <= 1'b1;
                end
            end
        end
    endgenerate

    // control and entry address registers; reserved bits are dropped
    always_ff @(posedge clock) begin
        if (!resetn) begin
            enable <= icache_pkg::ENABLE_RESET;
            freeze <= icache_pkg::FREEZE_RESET;
        end else if (ctl_wr_control) begin
            enable <= ctl_wdata[icache_pkg::CTL_ENABLE_BIT];
            freeze <= ctl_wdata[icache_pkg::CTL_FREEZE_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            entry_index <= icache_pkg::ENTRY_INDEX_RESET;
        end else if (ctl_wr_entry) begin
            entry_index <=
                ctl_wdata[icache_pkg::INDEX_MSB:icache_pkg::INDEX_LSB];
        end
    end

    // register port answer, one cycle after the access
    always_ff @(posedge clock) begin
        if (!resetn) begin
            ctl_ack <= 1'b0;
            ctl_privilege_error <= 1'b0;
            ctl_rdata <= '0;
        end else begin
            ctl_ack <= ctl_allowed;
            ctl_privilege_error <= ctl_denied;
            if (ctl_allowed && !ctl_write) begin
                ctl_rdata <= read_view;
            end
        end
    end

endmodule

// [tb/icache_properties.sv]
`timescale 1ns/1ps
module icache_properties (
    input wire logic clock,
    input wire logic resetn,
    input wire logic fetch_is_instruction,
    input wire logic fetch_done,
    input wire logic fetch_from_cache,
    input wire logic ctl_valid,
    input wire logic ctl_write,
    input wire logic ctl_select,
    input wire logic ctl_supervisor,
    input wire logic ctl_ack,
    input wire logic ctl_privilege_error,
    input wire logic [31:0] ctl_rdata,
    input wire logic ext_req,
    input wire logic [31:0] ext_addr,
    input wire logic ext_ack,
    input wire logic cache_inhibit_pin_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    chk_ext_aligned: assert property (
        ext_req |-> ext_addr[1:0] == 2'h0) else $error("ext addr unaligned");
    chk_ext_held: assert property (
        ext_req && !ext_ack |=> ext_req && $stable(ext_addr))
        else $error("ext request dropped");
    chk_miss_done: assert property (
        ext_req && ext_ack |=> fetch_done && !fetch_from_cache && !ext_req)
        else $error("miss not completed");
    chk_hit_cause: assert property (
        fetch_done && fetch_from_cache |->
        $past(cache_inhibit_pin_n) && $past(fetch_is_instruction))
        else $error("hit without cacheable fetch");
    chk_super_ack: assert property (
        ctl_valid && ctl_supervisor |=> ctl_ack && !ctl_privilege_error)
        else $error("supervisor access not acked");
    chk_user_refused: assert property (
        ctl_valid && !ctl_supervisor |=>
        ctl_privilege_error && !ctl_ack && $stable(ctl_rdata))
        else $error("user access not refused");
    chk_control_zeros: assert property (
        ctl_valid && ctl_supervisor && !ctl_write && !ctl_select
        |=> ctl_rdata[31:2] == 30'h0) else $error("control bits not zero");
    chk_entry_zeros: assert property (
        ctl_valid && ctl_supervisor && !ctl_write && ctl_select
        |=> ctl_rdata[31:8] == 24'h0 && ctl_rdata[1:0] == 2'h0)
        else $error("entry address bits not zero");
endmodule
bind direct_mapped_instruction_cache icache_properties chk_u (.*);

// [tb/ext_model.sv]
`timescale 1ns/1ps
module ext_model (
    input wire logic clock,
    input wire logic ext_req,
    input wire logic [31:0] ext_addr,
    input wire logic [1:0] dly,
    output logic ext_ack = 1'h0,
    output logic [31:0] ext_data = 32'h0
);
    logic [1:0] cnt = 2'h0;
    // data toggles outside the ack cycle so a late sample shows up
    always @(posedge clock) begin
        ext_data <= ~ext_data;
        if (ext_ack) begin
            ext_ack <= 1'h0;
            cnt <= dly;
        end else if (ext_req && cnt == 2'h0) begin
            ext_ack <= 1'h1;
            ext_data <= {ext_addr[31:16] ^ ext_addr[15:0], ext_addr[15:0]};
        end else if (ext_req) begin
            cnt <= cnt - 2'h1;
        end
    end
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin \
    n_mismatch++; $display("ERROR %s exp %h got %h", n, e, a); end end
module tb_top;
    logic clock = 1'h0;
    logic resetn, fetch_req, fetch_is_instruction, fetch_done;
    logic fetch_from_cache, ctl_valid, ctl_write, ctl_select;
    logic ctl_supervisor, ctl_ack, ctl_privilege_error, ext_req, ext_ack;
    logic cache_inhibit_pin_n;
    logic [31:0] fetch_addr, ctl_wdata, ctl_rdata, ext_addr, ext_data, r, d;
    logic [2:0] fetch_space_code, ext_space_code;
    logic [15:0] fetch_data;
    logic [1:0] dly;
    int n_mismatch = 0, check_count = 0, seed = 43753;
    logic [16:0] fq[$];
    logic [32:0] cq[$];
    logic [32:0] e;
    logic vld[64];
    logic [24:0] tg[64];
    logic en, frz;
    logic [5:0] idx;
    direct_mapped_instruction_cache dut_u (.*);
    ext_model ext_u (.*);
    always #20 clock = ~clock;
    task end_sim;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(negedge clock) begin
        if (fetch_done) begin
            e = {16'h0, fq.pop_front()};
            `CHK("fetch", e[16:0], {fetch_from_cache, fetch_data})
        end
        if (ctl_ack) begin
            e = cq.pop_front();
            if (e[32]) begin
                `CHK("ctl_rdata", e[31:0], ctl_rdata)
            end
        end
    end
    task automatic fetch(input logic [31:0] a, input logic ins);
        logic [5:0] i = a[7:2];
        logic [24:0] t = {a[31:8], fetch_space_code[2]};
        logic ok = ins && en && cache_inhibit_pin_n;
        logic hit = ok && vld[i] && tg[i] == t;
        fq.push_back({hit, a[1] ? {a[15:2], 2'h0} :
            a[31:16] ^ {a[15:2], 2'h0}});
        if (!hit && ok && !frz) begin
            vld[i] = 1'h1;
            tg[i] = t;
        end
        fetch_addr = a;
        fetch_is_instruction = ins;
        fetch_req = 1'h1;
        for (int k = 0; k < 40; k++) begin
            @(negedge clock);
            if (fetch_done) break;
        end
        fetch_req = 1'h0;
        if (!fetch_done) begin
            n_mismatch++;
            end_sim;
        end
        // let an edge pass so a following request is a fresh assignment
        @(negedge clock);
    endtask
    task ctl(input logic wr, input logic sel, input logic sup);
        if (sup && wr && sel) idx = d[7:2];
        if (sup && wr && !sel) begin
            en = d[0];
            frz = d[1];
            if (d[3]) vld = '{default: 1'h0};
            if (d[2]) vld[idx] = 1'h0;
        end
        if (sup) begin
            cq.push_back({!wr, sel ? {24'h0, idx, 2'h0} :
                {30'h0, frz, en}});
        end
        {ctl_valid, ctl_write} = {1'h1, wr};
        {ctl_select, ctl_supervisor} = {sel, sup};
        ctl_wdata = d;
        @(negedge clock);
        ctl_valid = 1'h0;
        @(negedge clock);
    endtask
    task rst;
        resetn = 1'h0;
        {fetch_req, ctl_valid, en, frz, idx} = '0;
        vld = '{default: 1'h0};
        repeat (20) @(negedge clock);
        resetn = 1'h1;
        d = 32'h0;
        ctl(1'h0, 1'h0, 1'h1);
        ctl(1'h0, 1'h1, 1'h1);
    endtask
    initial begin
        {ctl_write, ctl_select, ctl_supervisor, fetch_is_instruction} = '0;
        {fetch_addr, ctl_wdata, fetch_space_code, dly} = '0;
        cache_inhibit_pin_n = 1'h1;
        rst();
        d = 32'hFFFFFFF1;
        ctl(1'h1, 1'h0, 1'h0);
        ctl(1'h1, 1'h0, 1'h1);
        ctl(1'h0, 1'h0, 1'h1);
        for (int n = 0; n < 600; n++) begin
            if (n == 300) rst();
            r = $random(seed);
            d = $random(seed);
            d[0] = d[0] | d[9];
            d[3] = d[3] & d[10] & d[11];
            dly = r[23:22];
            fetch_space_code = r[12:10];
            // few tags over all 64 indexes so hits and conflicts are frequent
            case (r[15:13])
                3'h0: ctl(1'h1, r[16], r[17] | r[18]);
                3'h1: ctl(1'h0, r[16], r[17] | r[18]);
                3'h2: cache_inhibit_pin_n = r[16] | r[17];
                default: fetch({r[8] ? 8'hFF : 8'h00, 16'h0, r[7:1], 1'h0},
                    r[20] | r[21]);
            endcase
        end
        repeat (4) @(negedge clock);
        end_sim;
    end
endmodule
